// File: efc_pkg.sv
// Package with register indices, field positions and reset values.
package efc_pkg;
    // ****************************************************************
    // Register indices
    // ****************************************************************
    localparam logic [31:0] FEATURE_CTRL_IDX = 32'hc0000080;
    localparam logic [31:0] SYS_CONFIG_IDX = 32'hc0010010;
    localparam logic [31:0] XCR_ZERO_IDX = 32'h00000000;
    // ****************************************************************
    // Feature control fields
    // ****************************************************************
    localparam int SCE_POS = 0;
    localparam int LME_POS = 8;
    localparam int LMA_POS = 10;
    localparam int NXE_POS = 11;
    localparam int VIRT_POS = 12;
    localparam int SLE_POS = 13;
    localparam int FSAVE_POS = 14;
    localparam int TCX_POS = 15;
    localparam logic [63:0] FEATURE_WR_MASK = 64'h000000000000f901;
    localparam logic [63:0] FEATURE_RESET = 64'h0000000000000000;
    // ****************************************************************
    // System configuration fields
    // ****************************************************************
    localparam int FIX_ATTR_POS = 18;
    localparam int ATTR_MOD_POS = 19;
    localparam int VAR_RANGE_POS = 20;
    localparam int SECOND_TOP_OF_MEMORY_ENABLE_EN_POS = 21;
    localparam int FWB_POS = 22;
    localparam logic [31:0] SYS_CONFIG_WR_MASK = 32'h007c0000;
    localparam logic [31:0] SYS_CONFIG_RESET = 32'h00000000;
    localparam logic [63:0] XCR_ZERO_RESET = 64'h0000000000000001;
    // ****************************************************************
    // Access state machine
    // ****************************************************************
    typedef enum logic [1:0]
    {
        EFC_IDLE = 2'b00,
        EFC_ANSWER = 2'b01,
        EFC_FAULT = 2'b11
    } efc_state_e;
endpackage

// File: efc_mode_decode.sv
// Operating mode and feature gating decode from the control bits.
`timescale 1ns/1ps
module efc_mode_decode
(
    // Control state
    input wire logic lma_i,
    input wire logic code_long_i,
    input wire logic cpl_zero_i,
    input wire logic fsave_i,
    input wire logic sle_i,
    // Mode outputs
    output logic legacy_o,
    output logic mode64_o,
    output logic compat_o,
    output logic fast_save_o,
    output logic limit_chk_o
);
    always_comb
    begin
        legacy_o = !lma_i; // R5
        mode64_o = lma_i && code_long_i; // R4
        compat_o = lma_i && !code_long_i; // R4
        fast_save_o = fsave_i && lma_i && code_long_i && cpl_zero_i; // R14 R15
        limit_chk_o = sle_i && lma_i && code_long_i; // R13
    end
endmodule

// File: efc_regs.sv
// Extended feature control register bank.
//
// Contract
// R1: System-call extension bit set lets the fast system-call pair execute.
// R2: Long-mode enable only arms; enabling paging later activates long mode.
// R3: Long-mode active is set only when long-mode enable and paging both on.
// R4: With long mode active, code-segment long flag picks 64-bit or compat.
// R5: With long mode inactive, run as legacy 32-bit with 64-bit features off.
// R6: Writing a long-mode active value unlike the hardware state faults.
// R7: Software writes the control register read-modify-write keeping active.
// R8: No-execute enable bit switches no-execute page protection on and off; the code keeps it off while long mode is inactive.
// R9: Software should check feature flags before setting no-execute enable.
// R10: Virtualisation enable clear makes virtualisation ops fault.
// R11: Virtualisation enable bit resets to zero.
// R12: Hypervisor keeps guests from writing the feature control register.
// R13: Segment-limit enable adds limit checks in 64-bit mode.
// R14: Fast-save skips vector registers for state save at level 0, 64-bit.
// R15: Fast-save is inert elsewhere and never touches x87 or control word.
// R16: Translation-cache extension clear: drop all cached upper entries.
// R17: Translation-cache extension set: drop only upper entries on the path.
// R18: Software sets translation-cache extension only if support is flagged.
// R19: Only extended control register zero is defined; others are reserved.
// R20: These registers are reached only by the privileged access commands.
// R21: System configuration holds enables at bits 18 to 22, rest reserved.
// R22: Fixed-range attribute enable turns fixed-range memory attributes on.
// R23: Modify enable clear freezes attribute bits and makes them read zero.
// R24: Variable-range enable turns top-of-memory and I/O range registers on.
// R25: Second top-of-memory enable turns the second top register on.
`timescale 1ns/1ps
module efc_regs
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // Register access command
    input wire logic ACC_REQ_I,
    input wire logic ACC_WRITE_I,
    input wire logic ACC_XCR_I,
    input wire logic ACC_PRIV_I,
    input wire logic [31:0] ACC_INDEX_I,
    input wire logic [63:0] ACC_WDATA_I,
    // Register access answer
    output logic ACC_DONE_O,
    output logic ACC_GP_FAULT_O,
    output logic [63:0] ACC_RDATA_O,
    // Core state
    input wire logic PAGING_ON_I,
    input wire logic CODE_LONG_I,
    input wire logic CPL_ZERO_I,
    // Instruction checks
    input wire logic FAST_CALL_OP_I,
    input wire logic VIRT_OP_I,
    output logic UD_FAULT_O,
    // Attribute bit storage path
    input wire logic ATTR_WR_I,
    input wire logic [1:0] ATTR_WDATA_I,
    output logic [1:0] ATTR_RDATA_O,
    // Feature controls
    output logic FAST_CALL_EN_O,
    output logic NO_EXEC_EN_O,
    output logic LONG_MODE_ACTIVE_O,
    output logic LEGACY_MODE_O,
    output logic MODE64_O,
    output logic COMPAT_MODE_O,
    output logic LIMIT_CHECK_EN_O,
    output logic FAST_SAVE_SKIP_O,
    output logic INVAL_PATH_ONLY_O,
    // Memory attribute controls
    output logic FIX_ATTR_EN_O,
    output logic VAR_RANGE_EN_O,
    output logic SECOND_TOP_OF_MEMORY_ENABLE_EN_O,
    output logic FORCE_WB_O
);
    // ****************************************************************
    // State
    // ****************************************************************
    efc_pkg::efc_state_e state_q;
    efc_pkg::efc_state_e state_d;
    logic [63:0] feature_q;
    logic [31:0] sys_config_q;
    logic [63:0] xcr_zero_q;
    logic [1:0] attr_q;
    logic lma_q;
    logic [63:0] rdata_q;
    logic [63:0] rdata_d;
    logic ud_q;
    logic hit_feature;
    logic hit_sys;
    logic hit_xcr;
    logic bad_access;
    logic lma_wr_mismatch;
    logic wr_ok;
    logic legacy;
    logic mode64;
    logic compat;
    logic fast_save;
    logic limit_chk;

    // ****************************************************************
    // Decode
    // ****************************************************************
    function automatic logic index_hit(input logic [31:0] idx,
                                       input logic [31:0] ref_idx);
        index_hit = (idx == ref_idx);
    endfunction

    always_comb
    begin
        hit_feature = !ACC_XCR_I &&
                      index_hit(ACC_INDEX_I, efc_pkg::FEATURE_CTRL_IDX);
        hit_sys = !ACC_XCR_I &&
                  index_hit(ACC_INDEX_I, efc_pkg::SYS_CONFIG_IDX);
        hit_xcr = ACC_XCR_I &&
                  index_hit(ACC_INDEX_I, efc_pkg::XCR_ZERO_IDX); // R19
        // Long-mode active tracks hardware; a written value must match it.
        lma_wr_mismatch = hit_feature && ACC_WRITE_I &&
                          (ACC_WDATA_I[efc_pkg::LMA_POS] != lma_q); // R6
        bad_access = !ACC_PRIV_I || // R20
                     !(hit_feature || hit_sys || hit_xcr) || // R19
                     lma_wr_mismatch; // R6
        // Writes land only on the taking edge, never while the answer stands.
        wr_ok = ACC_REQ_I && ACC_WRITE_I && !bad_access &&
                (state_q == efc_pkg::EFC_IDLE);
    end

    // ****************************************************************
    // Access sequencing
    // ****************************************************************
    // Requests that arrive while the answer stands are dropped, so a master
    // that holds its request through the answer is not taken twice.
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            efc_pkg::EFC_IDLE:
            begin
                if (ACC_REQ_I)
                begin
                    if (bad_access)
                    begin
                        state_d = efc_pkg::EFC_FAULT;
                    end
                    else
                    begin
                        state_d = efc_pkg::EFC_ANSWER;
                    end
                end
            end
            efc_pkg::EFC_ANSWER:
            begin
                state_d = efc_pkg::EFC_IDLE;
            end
            efc_pkg::EFC_FAULT:
            begin
                state_d = efc_pkg::EFC_IDLE;
            end
            default:
            begin
                state_d = efc_pkg::EFC_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            state_q <= efc_pkg::EFC_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Feature control register
    // ****************************************************************
    // Reserved bits never store, so reads of them return zero.
    // The active bit is not kept here; reads take it from the tracking flop.
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            feature_q <= efc_pkg::FEATURE_RESET; // R11
        end
        else if (wr_ok && hit_feature)
        begin
            feature_q <= ACC_WDATA_I & efc_pkg::FEATURE_WR_MASK;
        end
    end

    // Activation waits for paging after the arm bit; leaving either
    // deactivates long mode on the next clock edge.
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            lma_q <= 1'b0;
        end
        else
        begin
            lma_q <= feature_q[efc_pkg::LME_POS] && PAGING_ON_I; // R2 R3
        end
    end

    // ****************************************************************
    // System configuration and extended control registers
    // ****************************************************************
    // Reserved system configuration bits never store and read as zero.
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            sys_config_q <= efc_pkg::SYS_CONFIG_RESET;
        end
        else if (wr_ok && hit_sys)
        begin
            sys_config_q <= ACC_WDATA_I[31:0] &
                            efc_pkg::SYS_CONFIG_WR_MASK; // R21
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            xcr_zero_q <= efc_pkg::XCR_ZERO_RESET;
        end
        else if (wr_ok && hit_xcr)
        begin
            // Every bit of register zero is writable.
            xcr_zero_q <= ACC_WDATA_I;
        end
    end

    // The attribute bits live elsewhere in the memory-type logic; only
    // their gated copy is modelled here.
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            attr_q <= 2'h0;
        end
        else if (ATTR_WR_I && sys_config_q[efc_pkg::ATTR_MOD_POS])
        begin
            attr_q <= ATTR_WDATA_I; // R23
        end
    end

    // ****************************************************************
    // Read data and answer
    // ****************************************************************
    // Read data is captured on the taking edge and then holds until the
    // next good read, so a slow master can still pick it up.
    always_comb
    begin
        rdata_d = rdata_q;
        if (ACC_REQ_I && !ACC_WRITE_I && !bad_access &&
            state_q == efc_pkg::EFC_IDLE)
        begin
            if (hit_feature)
            begin
                rdata_d = feature_q;
                rdata_d[efc_pkg::LMA_POS] = lma_q;
            end
            else if (hit_sys)
            begin
                rdata_d = {32'h00000000, sys_config_q};
            end
            else
            begin
                rdata_d = xcr_zero_q;
            end
        end
    end

    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            rdata_q <= 64'h0000000000000000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign ACC_DONE_O = (state_q != efc_pkg::EFC_IDLE);
    assign ACC_GP_FAULT_O = (state_q == efc_pkg::EFC_FAULT);
    assign ACC_RDATA_O = rdata_q;

    // ****************************************************************
    // Instruction gating
    // ****************************************************************
    // The fault is registered so the core sees it one cycle after the
    // opcode strobe; a combinational path would reach deep into decode.
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RESET_N_I)
        begin
            ud_q <= 1'b0;
        end
        else
        begin
            ud_q <= (VIRT_OP_I && !feature_q[efc_pkg::VIRT_POS]) || // R10
                    (FAST_CALL_OP_I && !feature_q[efc_pkg::SCE_POS]); // R1
        end
    end

    assign UD_FAULT_O = ud_q;

    // ****************************************************************
    // Mode decode
    // ****************************************************************
    // The decode sits in its own block so other core logic can share it
    // without pulling in the register bank.
    efc_mode_decode efc_mode_decode_inst
    (
        .lma_i(lma_q),
        .code_long_i(CODE_LONG_I),
        .cpl_zero_i(CPL_ZERO_I),
        .fsave_i(feature_q[efc_pkg::FSAVE_POS]),
        .sle_i(feature_q[efc_pkg::SLE_POS]),
        .legacy_o(legacy),
        .mode64_o(mode64),
        .compat_o(compat),
        .fast_save_o(fast_save),
        .limit_chk_o(limit_chk)
    );

    assign FAST_CALL_EN_O = feature_q[efc_pkg::SCE_POS]; // R1
    assign NO_EXEC_EN_O = feature_q[efc_pkg::NXE_POS] && !legacy; // R8 R5
    assign LONG_MODE_ACTIVE_O = lma_q;
    assign LEGACY_MODE_O = legacy; // R5
    assign MODE64_O = mode64; // R4
    assign COMPAT_MODE_O = compat; // R4
    assign LIMIT_CHECK_EN_O = limit_chk; // R13
    // Skipping only the vector file leaves x87 and control word saved.
    assign FAST_SAVE_SKIP_O = fast_save; // R14 R15
    assign INVAL_PATH_ONLY_O = feature_q[efc_pkg::TCX_POS]; // R16 R17
    assign FIX_ATTR_EN_O = sys_config_q[efc_pkg::FIX_ATTR_POS]; // R22
    assign VAR_RANGE_EN_O = sys_config_q[efc_pkg::VAR_RANGE_POS]; // R24
    assign SECOND_TOP_OF_MEMORY_ENABLE_EN_O = sys_config_q[efc_pkg::SECOND_TOP_OF_MEMORY_ENABLE_EN_POS]; // R25
    // Forcing write-back above four gigabytes only matters downstream, once
    // the second top-of-memory register is enabled as well.
    assign FORCE_WB_O = sys_config_q[efc_pkg::FWB_POS]; // R21
    assign ATTR_RDATA_O = sys_config_q[efc_pkg::ATTR_MOD_POS] ?
                          attr_q : 2'h0; // R23
endmodule

// File: efc_regs_props.sv
// Concurrent checks on the ports of the feature control register bank.
`timescale 1ns/1ps
module efc_regs_props
(
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // Access and core state
    input wire logic ACC_REQ_I,
    input wire logic ACC_PRIV_I,
    input wire logic PAGING_ON_I,
    input wire logic CODE_LONG_I,
    input wire logic CPL_ZERO_I,
    input wire logic FAST_CALL_OP_I,
    // Observed outputs
    input wire logic ACC_DONE_O,
    input wire logic ACC_GP_FAULT_O,
    input wire logic UD_FAULT_O,
    input wire logic FAST_CALL_EN_O,
    input wire logic LONG_MODE_ACTIVE_O,
    input wire logic LEGACY_MODE_O,
    input wire logic MODE64_O,
    input wire logic COMPAT_MODE_O,
    input wire logic LIMIT_CHECK_EN_O,
    input wire logic FAST_SAVE_SKIP_O
);
    // ****************************************************************
    // Access handshake
    // ****************************************************************
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_taken;
        ACC_REQ_I && !ACC_DONE_O;
    endsequence
    sequence s_answer;
        ACC_DONE_O ##1 !ACC_DONE_O;
    endsequence
    chk_done_pulse: assert property (s_taken |=> s_answer)
        else $error("access answer is not a single pulse");
    chk_priv_fault: assert property (
        s_taken ##0 !ACC_PRIV_I |=> ACC_GP_FAULT_O)
        else $error("unprivileged access not refused");
    chk_fault_done: assert property (ACC_GP_FAULT_O |-> ACC_DONE_O)
        else $error("fault flag without answer");
    // ****************************************************************
    // Mode decode and instruction gating
    // ****************************************************************
    chk_active_cause: assert property (
        $rose(LONG_MODE_ACTIVE_O) |-> $past(PAGING_ON_I))
        else $error("long mode active without paging");
    chk_legacy_mode: assert property (
        LEGACY_MODE_O == !LONG_MODE_ACTIVE_O)
        else $error("legacy mode disagrees with active bit");
    chk_mode_select: assert property (
        LONG_MODE_ACTIVE_O |-> MODE64_O == CODE_LONG_I &&
        COMPAT_MODE_O == !CODE_LONG_I)
        else $error("wrong 64-bit or compatibility selection");
    chk_save_scope: assert property (
        FAST_SAVE_SKIP_O |-> MODE64_O && CPL_ZERO_I)
        else $error("fast save outside 64-bit level zero");
    chk_limit_scope: assert property (LIMIT_CHECK_EN_O |-> MODE64_O)
        else $error("limit checks outside 64-bit mode");
    chk_call_ud: assert property (
        FAST_CALL_OP_I && !FAST_CALL_EN_O |=> UD_FAULT_O)
        else $error("disabled system call not refused");
endmodule
bind efc_regs efc_regs_props efc_regs_props_inst (.*);

// File: efc_regs_tb.sv
// Self-checking bench for the feature control register bank.
`timescale 1ns/1ps
module efc_regs_tb;
    logic REF_CLK_I = 1'h0, RESET_N_I = 1'h0, ACC_REQ_I = 1'h0;
    logic ACC_WRITE_I = 1'h0, ACC_XCR_I = 1'h0, ACC_PRIV_I = 1'h1;
    logic PAGING_ON_I = 1'h0, CODE_LONG_I = 1'h0, CPL_ZERO_I = 1'h1;
    logic FAST_CALL_OP_I = 1'h0, VIRT_OP_I = 1'h0, ATTR_WR_I = 1'h0;
    logic [1:0] ATTR_WDATA_I = 2'h0;
    logic [31:0] ACC_INDEX_I = 32'h0;
    logic [63:0] ACC_WDATA_I = 64'h0;
    logic ACC_DONE_O, ACC_GP_FAULT_O, UD_FAULT_O, FAST_CALL_EN_O;
    logic NO_EXEC_EN_O, LONG_MODE_ACTIVE_O, LEGACY_MODE_O, MODE64_O;
    logic COMPAT_MODE_O, LIMIT_CHECK_EN_O, FAST_SAVE_SKIP_O;
    logic INVAL_PATH_ONLY_O, FIX_ATTR_EN_O, VAR_RANGE_EN_O, SECOND_TOP_OF_MEMORY_ENABLE_EN_O;
    logic FORCE_WB_O;
    logic [63:0] ACC_RDATA_O;
    logic [1:0] ATTR_RDATA_O;
    int num_errors = 0;
    int n_tests = 0;
    localparam logic [31:0] FC = efc_pkg::FEATURE_CTRL_IDX;
    localparam logic [31:0] SC = efc_pkg::SYS_CONFIG_IDX;

    efc_regs efc_regs_inst (.*);

    always #2.5 REF_CLK_I = ~REF_CLK_I;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic print_verdict;
        if (num_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
            num_errors++;
        end
    endtask

    // The request stands through the answer edge, where the design ignores it.
    task automatic acc(input logic w, input logic x, input logic p,
                       input logic [31:0] i, input logic [63:0] d,
                       input logic f);
        @(posedge REF_CLK_I);
        ACC_REQ_I <= 1'h1;
        ACC_WRITE_I <= w;
        ACC_XCR_I <= x;
        ACC_PRIV_I <= p;
        ACC_INDEX_I <= i;
        ACC_WDATA_I <= d;
        @(posedge REF_CLK_I);
        #1;
        cmp({62'h0, ACC_DONE_O, ACC_GP_FAULT_O}, {62'h0, 1'h1, f});
        @(posedge REF_CLK_I);
        ACC_REQ_I <= 1'h0;
        #1;
    endtask

    task automatic rd(input logic x, input logic [31:0] i,
                      input logic [63:0] e);
        acc(1'h0, x, 1'h1, i, 64'h0, 1'h0);
        cmp(ACC_RDATA_O, e);
    endtask

    task automatic op(input logic c, input logic v, input logic e);
        @(posedge REF_CLK_I);
        FAST_CALL_OP_I <= c;
        VIRT_OP_I <= v;
        @(posedge REF_CLK_I);
        FAST_CALL_OP_I <= 1'h0;
        VIRT_OP_I <= 1'h0;
        #1;
        cmp(UD_FAULT_O, e);
    endtask

    task automatic attr(input logic [1:0] d);
        @(posedge REF_CLK_I);
        ATTR_WR_I <= 1'h1;
        ATTR_WDATA_I <= d;
        @(posedge REF_CLK_I);
        ATTR_WR_I <= 1'h0;
        #1;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK_I);
        #1;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        cmp(LEGACY_MODE_O, 64'h1);
        rd(1'h0, FC, 64'h0);
        rd(1'h0, SC, 64'h0);
        rd(1'h1, 32'h0, 64'h1);
    endtask

    task automatic t_map;
        acc(1'h1, 1'h0, 1'h1, FC, 64'hffffffff_fffffbff, 1'h0);
        rd(1'h0, FC, 64'hf901);
        cmp(FAST_CALL_EN_O, 64'h1);
        cmp(INVAL_PATH_ONLY_O, 64'h1);
        cmp(LONG_MODE_ACTIVE_O, 64'h0);
        acc(1'h1, 1'h0, 1'h1, SC, 64'hffffffff_ffffffff, 1'h0);
        rd(1'h0, SC, 64'h7c0000);
        cmp({FIX_ATTR_EN_O, VAR_RANGE_EN_O, SECOND_TOP_OF_MEMORY_ENABLE_EN_O}, 64'h7);
        cmp(FORCE_WB_O, 64'h1);
        acc(1'h0, 1'h0, 1'h1, 32'hc0000081, 64'h0, 1'h1);
        acc(1'h0, 1'h1, 1'h1, 32'h1, 64'h0, 1'h1);
        acc(1'h1, 1'h1, 1'h1, 32'h0, 64'h7, 1'h0);
        rd(1'h1, 32'h0, 64'h7);
        acc(1'h1, 1'h0, 1'h0, FC, 64'h0, 1'h1);
        rd(1'h0, FC, 64'hf901);
    endtask

    task automatic t_long;
        @(posedge REF_CLK_I);
        PAGING_ON_I <= 1'h1;
        CODE_LONG_I <= 1'h1;
        cyc(2);
        cmp(LONG_MODE_ACTIVE_O, 64'h1);
        cmp({MODE64_O, COMPAT_MODE_O, LEGACY_MODE_O}, 64'h4);
        cmp({LIMIT_CHECK_EN_O, FAST_SAVE_SKIP_O}, 64'h3);
        cmp(NO_EXEC_EN_O, 64'h1);
        @(posedge REF_CLK_I);
        CPL_ZERO_I <= 1'h0;
        CODE_LONG_I <= 1'h0;
        cyc(1);
        cmp({MODE64_O, COMPAT_MODE_O, FAST_SAVE_SKIP_O}, 64'h2);
        cmp(LIMIT_CHECK_EN_O, 64'h0);
        acc(1'h1, 1'h0, 1'h1, FC, 64'hf901, 1'h1);
        rd(1'h0, FC, 64'hfd01);
        acc(1'h1, 1'h0, 1'h1, FC, 64'hf501, 1'h0);
        cmp(NO_EXEC_EN_O, 64'h0);
        @(posedge REF_CLK_I);
        PAGING_ON_I <= 1'h0;
        CPL_ZERO_I <= 1'h1;
        cyc(2);
        cmp({LONG_MODE_ACTIVE_O, LEGACY_MODE_O}, 64'h1);
    endtask

    task automatic t_ud;
        acc(1'h1, 1'h0, 1'h1, FC, 64'h0, 1'h0);
        cmp({FAST_CALL_EN_O, INVAL_PATH_ONLY_O}, 64'h0);
        op(1'h0, 1'h1, 1'h1);
        op(1'h1, 1'h0, 1'h1);
        acc(1'h1, 1'h0, 1'h1, FC, 64'h1001, 1'h0);
        op(1'h0, 1'h1, 1'h0);
        op(1'h1, 1'h0, 1'h0);
    endtask

    task automatic t_attr;
        acc(1'h1, 1'h0, 1'h1, SC, 64'h0, 1'h0);
        cmp({FIX_ATTR_EN_O, VAR_RANGE_EN_O, SECOND_TOP_OF_MEMORY_ENABLE_EN_O}, 64'h0);
        cmp(FORCE_WB_O, 64'h0);
        attr(2'h3);
        cmp(ATTR_RDATA_O, 64'h0);
        acc(1'h1, 1'h0, 1'h1, SC, 64'h80000, 1'h0);
        attr(2'h3);
        cmp(ATTR_RDATA_O, 64'h3);
        acc(1'h1, 1'h0, 1'h1, SC, 64'h0, 1'h0);
        cmp(ATTR_RDATA_O, 64'h0);
        attr(2'h1);
        acc(1'h1, 1'h0, 1'h1, SC, 64'h80000, 1'h0);
        cmp(ATTR_RDATA_O, 64'h3);
    endtask

    initial
    begin
        repeat (16) @(posedge REF_CLK_I);
        RESET_N_I <= 1'h1;
        #1;
        t_reset;
        t_map;
        t_long;
        t_ud;
        t_attr;
        print_verdict;
    end

    // Whole run takes well under a thousand cycles.
    initial
    begin
        #20000;
        num_errors++;
        print_verdict;
    end
endmodule
